// ---- core/osm_defs.svh ----
// constants for the option space and ram map block
// Behaviour
// [R1] size codes 01/10/11 end app area 3BFF/37FF/2FFF
// [R2] programming into boot area always rejected
// [R3] trim register sets fast oscillator, 32MHz factory
// [R4] each trim step shifts clock about 0.18%
// [R5] index at FE selects, data at FF
// [R6] software sets watchdog via index C1, OR 80
// [R7] software writes only valid option indexes
// [R8] ram 00-FF, upper half indirect only
// [R9] direct 80-FF reaches function registers
// [R10] external ram 0000-06FF via external moves
// [R11] 00-1F four banks chosen by PSW bits
// [R12] 20-2F byte or bit addressable, bits 00-7F
// [R13] software sets stack pointer E0-FF
// [R14] external address page high, pointer low
// [R15] page register keeps bits 2-0, reset zero
// [R16] size field read-only, 00 means no boot
// [R17] read-modify-write hits the same indexed option
// [R18] reserved page bits read zero, ignore writes
`ifndef OSM_DEFS_SVH
`define OSM_DEFS_SVH
`define OSM_ADDR_PAGE 8'hF7
`define OSM_ADDR_INDEX 8'hFE
`define OSM_ADDR_VALUE 8'hFF
`define OSM_OPT_CTM0 8'hC1
`define OSM_OPT_CTM1 8'hC2
`define OSM_OPT_TRIM 8'h83
`define OSM_OPT_FIRST 8'hC0
`define OSM_OPT_LAST 8'hC2
`define OSM_INDEX_RESET 8'h00
`define OSM_PAGE_RESET 3'h0
`define OSM_PAGE_MASK 8'h07
`define OSM_TRIM_FACTORY 8'h80
`define OSM_APP_END_NONE 14'h3FFF
`define OSM_APP_END_1K 14'h3BFF
`define OSM_APP_END_2K 14'h37FF
`define OSM_APP_END_4K 14'h2FFF
`define OSM_EXTERNAL_RAM_LAST 11'h6FF
`define OSM_UPPER_BIT 7
`define OSM_BANK_LAST 8'h1F
`define OSM_BIT_FIRST 8'h20
`define OSM_BIT_LAST 8'h2F
`endif

// ---- core/osm_pkg.sv ----
// types for the option space and ram map block
package osm_pkg;
  typedef enum logic [1:0] {
    OSM_BOOT_NONE = 2'h0,
    OSM_BOOT_1K = 2'h1,
    OSM_BOOT_2K = 2'h2,
    OSM_BOOT_4K = 2'h3
  } osm_boot_type;
  // cpu data access request
  typedef struct packed {
    logic valid;
    logic indirect;
    logic external;
    logic use_dptr;
    logic [7:0] addr;
    logic [15:0] dptr;
  } osm_acc_type;
  // decoded data target
  typedef struct packed {
    logic to_iram;
    logic to_sfr;
    logic to_external_ram;
    logic bad;
    logic [10:0] addr;
  } osm_map_type;
endpackage

// ---- core/osm_opt_mem.sv ----
// option store memory, four words, registered read
`timescale 1ns/10ps
`include "osm_defs.svh"
module osm_opt_mem (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [0:3];
  logic [7:0] next_rd;
  // read path picks the freshly written word first
  always_comb begin
    next_rd = mem[rd_addr];
    if (wr_en && wr_addr == rd_addr) begin
      next_rd = wr_data;
    end
  end
  // storage and registered read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem[0] <= 8'h00;
      mem[1] <= 8'h00;
      mem[2] <= 8'h00;
      mem[3] <= `OSM_TRIM_FACTORY;
      rd_data <= 8'h00;
    end else begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data <= next_rd;
    end
  end
endmodule // osm_opt_mem

// ---- core/osm_top.sv ----
// option space registers, boot area decode and data memory map
`timescale 1ns/10ps
`include "osm_defs.svh"
module osm_top (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  output logic [7:0] SFR_RDATA,
  input wire osm_pkg::osm_acc_type ACC,
  output osm_pkg::osm_map_type MAP,
  input wire logic [1:0] BANK_SEL,
  input wire logic [2:0] REG_NUM,
  output logic [7:0] BANK_REG_ADDR,
  input wire logic [7:0] BIT_ADDR,
  output logic [7:0] BIT_BYTE_ADDR,
  output logic [2:0] BIT_POS,
  input wire logic [1:0] BOOT_SIZE_CODE,
  input wire logic PROG_REQ,
  input wire logic [13:0] PROG_ADDR,
  output logic PROG_GRANT,
  output logic PROG_REJECT,
  output logic [13:0] APP_END,
  output logic [7:0] OSC_TRIM,
  output logic WDT_ENABLE
);
  // ****************************************
  // option index and page registers
  // ****************************************
  logic [7:0] index;
  logic [2:0] page;
  logic [7:0] next_index;
  logic [2:0] next_page;
  logic opt_hit;
  logic [1:0] opt_slot;
  logic opt_wr;
  logic [7:0] opt_rd;
  logic [7:0] opt_wdata;
  logic [1:0] boot_size;
  logic [7:0] ctm0;
  logic [7:0] trim;

  // which option word the index points at
  always_comb begin
    opt_hit = 1'b0;
    opt_slot = 2'h0;
    if (index >= `OSM_OPT_FIRST && index <= `OSM_OPT_LAST) begin
      opt_hit = 1'b1;
      opt_slot = index[1:0];
    end else if (index == `OSM_OPT_TRIM) begin
      opt_hit = 1'b1;
      opt_slot = 2'h3;
    end
  end

  // [R5] index and page writes
  always_comb begin
    next_index = index;
    next_page = page;
    if (SFR_WR && SFR_ADDR == `OSM_ADDR_INDEX) begin
      next_index = SFR_WDATA;
    end else if (SFR_WR && SFR_ADDR == `OSM_ADDR_PAGE) begin
      // [R15] only low three bits kept
      next_page = SFR_WDATA[2:0];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      index <= `OSM_INDEX_RESET;
      page <= `OSM_PAGE_RESET;
    end else begin
      index <= next_index;
      page <= next_page;
    end
  end

  // ****************************************
  // option data access
  // ****************************************
  // [R17] writes land on the indexed slot, size field protected
  always_comb begin
    opt_wr = SFR_WR && SFR_ADDR == `OSM_ADDR_VALUE && opt_hit;
    opt_wdata = SFR_WDATA;
    // [R16] boot size bits stay read-only
    if (index == `OSM_OPT_CTM1) begin
      opt_wdata = {SFR_WDATA[7:2], boot_size};
    end
  end

  // live copies of the option words that steer logic
  logic [7:0] shadow [0:3];
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      shadow[0] <= 8'h00;
      shadow[1] <= 8'h00;
      shadow[2] <= 8'h00;
      shadow[3] <= `OSM_TRIM_FACTORY;
    end else if (opt_wr) begin
      shadow[opt_slot] <= opt_wdata;
    end
  end

  // [R5] registered option storage read back through the data port
  osm_opt_mem u_mem (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .wr_en(opt_wr),
    .wr_addr(opt_slot),
    .wr_data(opt_wdata),
    .rd_addr(next_index == `OSM_OPT_TRIM ? 2'h3 : next_index[1:0]),
    .rd_data(opt_rd)
  );

  // boot size comes from the code option loader, never from software
  assign boot_size = BOOT_SIZE_CODE;
  assign ctm0 = shadow[1];
  assign trim = shadow[3];

  // ****************************************
  // register read port
  // ****************************************
  logic [7:0] next_rdata;
  logic opt_valid_q;
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      opt_valid_q <= 1'b0;
    end else begin
      opt_valid_q <= (next_index >= `OSM_OPT_FIRST && next_index <= `OSM_OPT_LAST)
        || next_index == `OSM_OPT_TRIM;
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (SFR_RD && SFR_ADDR == `OSM_ADDR_INDEX) begin
      next_rdata = index;
    end else if (SFR_RD && SFR_ADDR == `OSM_ADDR_VALUE) begin
      next_rdata = opt_valid_q ? opt_rd : 8'h00;
      // [R16] size field shows the loaded code
      if (index == `OSM_OPT_CTM1) begin
        next_rdata = {opt_rd[7:2], boot_size};
      end
    end else if (SFR_RD && SFR_ADDR == `OSM_ADDR_PAGE) begin
      // [R18] reserved bits read zero
      next_rdata = {5'h00, page};
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      SFR_RDATA <= 8'h00;
    end else begin
      SFR_RDATA <= next_rdata;
    end
  end

  // ****************************************
  // boot area and programming guard
  // ****************************************
  logic [13:0] app_end;
  always_comb begin
    app_end = `OSM_APP_END_NONE;
    // [R1] size code to application end
    case (osm_pkg::osm_boot_type'(boot_size))
      osm_pkg::OSM_BOOT_1K: app_end = `OSM_APP_END_1K;
      osm_pkg::OSM_BOOT_2K: app_end = `OSM_APP_END_2K;
      osm_pkg::OSM_BOOT_4K: app_end = `OSM_APP_END_4K;
      default: app_end = `OSM_APP_END_NONE;
    endcase
  end

  logic next_grant;
  logic next_reject;
  // [R2] anything above the app end is boot area
  always_comb begin
    next_grant = PROG_REQ && PROG_ADDR <= app_end;
    next_reject = PROG_REQ && PROG_ADDR > app_end;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      PROG_GRANT <= 1'b0;
      PROG_REJECT <= 1'b0;
      APP_END <= `OSM_APP_END_NONE;
      OSC_TRIM <= `OSM_TRIM_FACTORY;
      WDT_ENABLE <= 1'b0;
    end else begin
      PROG_GRANT <= next_grant;
      PROG_REJECT <= next_reject;
      APP_END <= app_end;
      // [R3] trim drives oscillator, [R4] linear step
      OSC_TRIM <= trim;
      WDT_ENABLE <= ctm0[7];
    end
  end

  // ****************************************
  // data memory map
  // ****************************************
  osm_pkg::osm_map_type next_map;
  always_comb begin
    next_map = '0;
    if (ACC.valid && ACC.external) begin
      // [R14] page high, pointer low, or data pointer
      next_map.addr = ACC.use_dptr ? ACC.dptr[10:0] : {page, ACC.addr};
      next_map.to_external_ram = 1'b1;
      // [R10] beyond 06FF not backed
      if (ACC.use_dptr ? (ACC.dptr > {5'h00, `OSM_EXTERNAL_RAM_LAST}) :
          ({page, ACC.addr} > `OSM_EXTERNAL_RAM_LAST)) begin
        next_map.to_external_ram = 1'b0;
        next_map.bad = 1'b1;
      end
    end else if (ACC.valid && ACC.addr[`OSM_UPPER_BIT] && !ACC.indirect) begin
      // [R9] direct upper half is function registers
      next_map.to_sfr = 1'b1;
      next_map.addr = {3'h0, ACC.addr};
    end else if (ACC.valid) begin
      // [R8] internal ram, lower both ways, upper indirect
      next_map.to_iram = 1'b1;
      next_map.addr = {3'h0, ACC.addr};
    end
  end

  logic [7:0] next_bank_addr;
  logic [7:0] next_bit_byte;
  always_comb begin
    // [R11] bank select picks eight-byte group
    next_bank_addr = {3'h0, BANK_SEL, REG_NUM};
    // [R12] bit address to byte 20-2F and bit
    next_bit_byte = `OSM_BIT_FIRST + {4'h0, BIT_ADDR[6:3]};
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      MAP <= '0;
      BANK_REG_ADDR <= 8'h00;
      BIT_BYTE_ADDR <= `OSM_BIT_FIRST;
      BIT_POS <= 3'h0;
    end else begin
      MAP <= next_map;
      BANK_REG_ADDR <= next_bank_addr;
      BIT_BYTE_ADDR <= next_bit_byte;
      BIT_POS <= BIT_ADDR[2:0];
    end
  end

  // ****************************************
  // checks
  // ****************************************
  boot_reject_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R2]
    PROG_REQ && PROG_ADDR > app_end |=> PROG_REJECT && !PROG_GRANT)
    else $error("boot area programming not rejected");
  size_decode_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R1]
    boot_size == 2'h2 |=> APP_END == `OSM_APP_END_2K)
    else $error("boot size decode wrong");
  index_write_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R5]
    SFR_WR && SFR_ADDR == `OSM_ADDR_INDEX |=> index == $past(SFR_WDATA))
    else $error("index not written");
  page_reserved_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R18]
    SFR_RD && SFR_ADDR == `OSM_ADDR_PAGE |=> SFR_RDATA[7:3] == 5'h00)
    else $error("reserved page bits not zero");
  page_keep_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R15]
    SFR_WR && SFR_ADDR == `OSM_ADDR_PAGE |=> page == $past(SFR_WDATA[2:0]))
    else $error("page bits not stored");
  direct_sfr_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R9]
    ACC.valid && !ACC.external && !ACC.indirect && ACC.addr[7] |=> MAP.to_sfr && !MAP.to_iram)
    else $error("direct upper access not to sfr");
  indirect_ram_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R8]
    ACC.valid && !ACC.external && ACC.indirect |=> MAP.to_iram)
    else $error("indirect access not to ram");
  external_ram_page_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R14]
    ACC.valid && ACC.external && !ACC.use_dptr |=> MAP.addr == {$past(page), $past(ACC.addr)})
    else $error("external address not page plus pointer");
  external_ram_limit_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R10]
    MAP.to_external_ram |-> MAP.addr <= `OSM_EXTERNAL_RAM_LAST)
    else $error("external ram beyond top");
  bank_addr_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R11]
    1'b1 |=> BANK_REG_ADDR <= `OSM_BANK_LAST && BANK_REG_ADDR[4:3] == $past(BANK_SEL))
    else $error("bank register address wrong");
  bit_byte_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R12]
    1'b1 |=> BIT_BYTE_ADDR <= `OSM_BIT_LAST)
    else $error("bit byte out of area");
  size_locked_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R16]
    opt_wr && index == `OSM_OPT_CTM1 |=> shadow[2][1:0] == $past(boot_size))
    else $error("boot size changed by software");
  trim_out_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R3]
    opt_wr && index == `OSM_OPT_TRIM |=> ##1 OSC_TRIM == $past(SFR_WDATA, 2))
    else $error("trim not forwarded");
  rmw_slot_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R17]
    opt_wr && index == `OSM_OPT_CTM0 |=> ##1 WDT_ENABLE == $past(SFR_WDATA[7], 2))
    else $error("option write missed indexed slot");
  size_one_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R1]
    boot_size == 2'h1 |=> APP_END == `OSM_APP_END_1K)
    else $error("one kilobyte boot decode wrong");
  size_four_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R1]
    boot_size == 2'h3 |=> APP_END == `OSM_APP_END_4K)
    else $error("four kilobyte boot decode wrong");
  boot_read_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R16]
    SFR_RD && SFR_ADDR == `OSM_ADDR_VALUE && index == `OSM_OPT_CTM1
      |=> SFR_RDATA[1:0] == $past(boot_size))
    else $error("size field readback wrong");
  app_grant_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R2]
    PROG_REQ && PROG_ADDR <= app_end |=> PROG_GRANT && !PROG_REJECT)
    else $error("application programming not granted");
endmodule // osm_top

// ---- sim/test_osm_top.sv ----
// self-checking testbench for the option space and ram map block
`timescale 1ns/10ps
`include "osm_defs.svh"
module test_osm_top;
  logic SYS_CLK;
  logic RST_N;
  logic SFR_WR;
  logic SFR_RD;
  logic [7:0] SFR_ADDR;
  logic [7:0] SFR_WDATA;
  logic [7:0] SFR_RDATA;
  osm_pkg::osm_acc_type ACC;
  osm_pkg::osm_map_type MAP;
  logic [1:0] BANK_SEL;
  logic [2:0] REG_NUM;
  logic [7:0] BANK_REG_ADDR;
  logic [7:0] BIT_ADDR;
  logic [7:0] BIT_BYTE_ADDR;
  logic [2:0] BIT_POS;
  logic PROG_REQ;
  logic [13:0] PROG_ADDR;
  logic PROG_GRANT;
  logic PROG_REJECT;
  logic [13:0] APP_END;
  logic [7:0] OSC_TRIM;
  logic WDT_ENABLE;
  logic [1:0] BOOT_SIZE_CODE;
  int fails = 0;
  int samples_checked = 0;
  logic [7:0] rmw;

  osm_top u_osm_top (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
    .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .ACC(ACC), .MAP(MAP),
    .BANK_SEL(BANK_SEL), .REG_NUM(REG_NUM), .BANK_REG_ADDR(BANK_REG_ADDR),
    .BIT_ADDR(BIT_ADDR), .BIT_BYTE_ADDR(BIT_BYTE_ADDR), .BIT_POS(BIT_POS),
    .BOOT_SIZE_CODE(BOOT_SIZE_CODE),
    .PROG_REQ(PROG_REQ), .PROG_ADDR(PROG_ADDR), .PROG_GRANT(PROG_GRANT),
    .PROG_REJECT(PROG_REJECT), .APP_END(APP_END), .OSC_TRIM(OSC_TRIM),
    .WDT_ENABLE(WDT_ENABLE));

  // 50 MHz system clock
  initial SYS_CLK = 1'b0;
  always #10 SYS_CLK = ~SYS_CLK;

  // ***************************************
  // bench tasks
  // ***************************************
  // step to just after the next rising edge
  task automatic tick();
    @(posedge SYS_CLK);
    #1;
  endtask

  // compare one result, report on mismatch
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // register write; strobe stays up until the next call
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    SFR_RD = 1'b0;
    SFR_WR = 1'b1;
    SFR_ADDR = a;
    SFR_WDATA = d;
    tick();
  endtask

  // register read, data valid just after the read edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    SFR_WR = 1'b0;
    SFR_RD = 1'b1;
    SFR_ADDR = a;
    tick();
    chk({8'h00, SFR_RDATA}, {8'h00, exp});
  endtask

  // bus idle for one cycle
  task automatic idle();
    SFR_WR = 1'b0;
    SFR_RD = 1'b0;
    tick();
  endtask

  // data access decode; flags are iram, sfr, external_ram, bad
  task automatic acc(input logic ind, input logic ext, input logic dp, input logic [7:0] a,
                     input logic [15:0] dptr, input logic [3:0] fl, input logic [10:0] ea);
    ACC.valid = 1'b1;
    ACC.indirect = ind;
    ACC.external = ext;
    ACC.use_dptr = dp;
    ACC.addr = a;
    ACC.dptr = dptr;
    tick();
    chk({12'h000, MAP.to_iram, MAP.to_sfr, MAP.to_external_ram, MAP.bad}, {12'h000, fl});
    if (!fl[0]) chk({5'h00, MAP.addr}, {5'h00, ea});
  endtask

  // one programming request, grant expected or not
  task automatic prog(input logic [13:0] a, input logic ok);
    PROG_REQ = 1'b1;
    PROG_ADDR = a;
    tick();
    PROG_REQ = 1'b0;
    chk({14'h0000, PROG_GRANT, PROG_REJECT}, {14'h0000, ok, !ok});
    tick();
  endtask

  // loaded size code: application end, then grant and reject at its edge
  task automatic boot(input logic [1:0] code, input logic [13:0] last);
    BOOT_SIZE_CODE = code;
    tick();
    chk({2'h0, APP_END}, {2'h0, last});
    prog(last, 1'b1);
    prog(last + 14'h0001, 1'b0);
  endtask

  // verdict and end of run
  task automatic complete_run();
    if (fails == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // bound on the whole run
  initial begin
    repeat (5000) @(posedge SYS_CLK);
    fails++;
    complete_run();
  end

  // ***************************************
  // main sequence
  // ***************************************
  initial begin
    RST_N = 1'b0;
    SFR_WR = 1'b0;
    SFR_RD = 1'b0;
    SFR_ADDR = 8'h00;
    SFR_WDATA = 8'h00;
    ACC = '0;
    BANK_SEL = 2'h0;
    REG_NUM = 3'h0;
    BIT_ADDR = 8'h00;
    PROG_REQ = 1'b0;
    PROG_ADDR = 14'h0000;
    BOOT_SIZE_CODE = 2'h0;
    repeat (6) tick();
    RST_N = 1'b1;
    chk({2'h0, APP_END}, 16'h3FFF);
    chk({8'h00, OSC_TRIM}, {8'h00, `OSM_TRIM_FACTORY});
    chk({15'h0000, WDT_ENABLE}, 16'h0000);
    rd(`OSM_ADDR_INDEX, `OSM_INDEX_RESET);
    rd(`OSM_ADDR_PAGE, 8'h00);
    // index still outside option space after reset: data port refuses
    wr(`OSM_ADDR_VALUE, 8'h5A);
    rd(`OSM_ADDR_VALUE, 8'h00);
    // watchdog option set by read-modify-write of the indexed word
    // valid option index
    wr(`OSM_ADDR_INDEX, `OSM_OPT_CTM0);
    rd(`OSM_ADDR_VALUE, 8'h00);
    rmw = SFR_RDATA | 8'h80;
    wr(`OSM_ADDR_VALUE, rmw);
    rd(`OSM_ADDR_VALUE, 8'h80);
    idle();
    chk({15'h0000, WDT_ENABLE}, 16'h0001);
    // trim word written and seen at the oscillator output
    wr(`OSM_ADDR_INDEX, `OSM_OPT_TRIM);
    wr(`OSM_ADDR_VALUE, 8'h81);
    rd(`OSM_ADDR_VALUE, 8'h81);
    chk({8'h00, OSC_TRIM}, 16'h0081);
    // boot size field refuses writes, no boot area
    wr(`OSM_ADDR_INDEX, `OSM_OPT_CTM1);
    wr(`OSM_ADDR_VALUE, 8'h03);
    rd(`OSM_ADDR_VALUE, 8'h00);
    chk({2'h0, APP_END}, 16'h3FFF);
    // loaded size codes, boundaries and readback through the data port
    idle();
    prog(14'h3FFF, 1'b1);
    prog(14'h0000, 1'b1);
    boot(2'h1, `OSM_APP_END_1K);
    rd(`OSM_ADDR_VALUE, 8'h01);
    boot(2'h2, `OSM_APP_END_2K);
    boot(2'h3, `OSM_APP_END_4K);
    BOOT_SIZE_CODE = 2'h0;
    tick();
    chk({2'h0, APP_END}, 16'h3FFF);
    // internal ram and function register decode
    acc(1'b0, 1'b0, 1'b0, 8'h30, 16'h0000, 4'b1000, 11'h030);
    acc(1'b1, 1'b0, 1'b0, 8'h85, 16'h0000, 4'b1000, 11'h085);
    acc(1'b1, 1'b0, 1'b0, 8'hE0, 16'h0000, 4'b1000, 11'h0E0);
    acc(1'b0, 1'b0, 1'b0, 8'h85, 16'h0000, 4'b0100, 11'h085);
    // external ram by data pointer, last and first beyond
    acc(1'b0, 1'b1, 1'b1, 8'h00, 16'h06FF, 4'b0010, 11'h6FF);
    acc(1'b0, 1'b1, 1'b1, 8'h00, 16'h0700, 4'b0001, 11'h000);
    ACC = '0;
    // page register high bits, reserved bits dropped
    wr(`OSM_ADDR_PAGE, 8'h01);
    idle();
    acc(1'b1, 1'b1, 1'b0, 8'h23, 16'h0000, 4'b0010, 11'h123);
    ACC = '0;
    wr(`OSM_ADDR_PAGE, 8'hFF);
    rd(`OSM_ADDR_PAGE, `OSM_PAGE_MASK);
    idle();
    acc(1'b1, 1'b1, 1'b0, 8'h00, 16'h0000, 4'b0001, 11'h000);
    ACC = '0;
    // register banks and bit area
    BANK_SEL = 2'h3;
    REG_NUM = 3'h5;
    BIT_ADDR = 8'h7F;
    tick();
    chk({8'h00, BANK_REG_ADDR}, 16'h001D);
    chk({8'h00, BIT_BYTE_ADDR}, {8'h00, `OSM_BIT_LAST});
    chk({13'h0000, BIT_POS}, 16'h0007);
    BANK_SEL = 2'h1;
    REG_NUM = 3'h0;
    BIT_ADDR = 8'h00;
    tick();
    chk({8'h00, BANK_REG_ADDR}, 16'h0008);
    chk({8'h00, BIT_BYTE_ADDR}, {8'h00, `OSM_BIT_FIRST});
    complete_run();
  end
endmodule // test_osm_top
